// [hw/ext_port_defs.svh]
`ifndef EXT_PORT_DEFS_SVH
`define EXT_PORT_DEFS_SVH
`define WIDTH_OK 3'h0
`define EPROM_WAIT 5'h10
`define SDRAM_CL 5'h02
`define FAIR_LIMIT 4'hf
`define BOOT_LAST 16'h00ff
`define REGION_HI 31
`define REGION_LO 30
`define REGION_SDRAM 2'b01
`define REGION_HOST 2'b11
`define BANK_HI 29
`define BANK_LO 28
`define MSEL_BIT 29
`define ROM_ADDR_W 24
`define ROM_PAD 8'h00
`define BYTE_PAD 24'h000000
`define WORD_PAD 16'h0000
`define CNT_PAD 3'h0
`define ONE32 32'h00000001
`define ONE24 24'h000001
`endif

// [hw/ext_port_pkg.sv]
package ext_port_pkg;
   typedef enum logic [5:0] {
      st_idle = 6'h01,
      st_addr = 6'h02,
      st_wait = 6'h04,
      st_gap = 6'h08,
      st_eprom = 6'h10,
      st_fly = 6'h20
   } mstate_t;
   typedef enum logic [1:0] {
      kind_pipe = 2'h0,
      kind_slow = 2'h1,
      kind_sdram = 2'h2
   } kind_t;
endpackage : ext_port_pkg

// [hw/bus_arbiter.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ext_port_defs.svh"
module bus_arbiter
   import ext_port_pkg::*;
(
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic [7:0] bus_req_i,
   input wire logic [2:0] proc_id_i,
   input wire logic own_req_i,
   input wire logic lock_i,
   input wire logic busy_i,
   input wire logic host_req_i,
   input wire logic back_off_n_i,
   output logic own_grant_o,
   output logic host_grant_o
);
   logic [2:0] owner, next_owner;
   logic [3:0] tenure, next_tenure;
   logic host_own, next_host_own;
   logic others;

   // every peer runs this same logic on the same lines, so all agree on the owner
   function automatic logic [2:0] rotate(input logic [7:0] req, input logic [2:0] cur);
      logic [2:0] pick;
      logic [2:0] idx;
      pick = cur;
      for (int i = 7; i >= 1; i--)
      begin
         idx = cur + 3'(i);
         if (req[idx])
            pick = idx;
      end
      return pick;
   endfunction : rotate

   always_comb
   begin
      others = |(bus_req_i & ~(8'h01 << owner));
      next_owner = owner;
      next_tenure = tenure;
      next_host_own = host_own;
      if (!back_off_n_i)
         next_host_own = 1'b1;
      else if (host_req_i && !lock_i && !busy_i)
         next_host_own = 1'b1;
      else if (!host_req_i)
         next_host_own = 1'b0;
      if (!bus_req_i[owner] || (others && tenure == `FAIR_LIMIT && !lock_i && !busy_i))
      begin
         next_owner = rotate(bus_req_i, owner);
         next_tenure = '0;
      end
      else if (others && tenure != `FAIR_LIMIT)
         next_tenure = tenure + 4'h1;
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         owner <= '0;
         tenure <= '0;
         host_own <= '0;
      end
      else
      begin
         owner <= next_owner;
         tenure <= next_tenure;
         host_own <= next_host_own;
      end
   end

   // no external arbiter: grant derived locally
   assign own_grant_o = !host_own && owner == proc_id_i && own_req_i;
   assign host_grant_o = host_own;

   lock_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      lock_i && bus_req_i[owner] |=> owner == $past(owner))
      else $error("owner changed under lock");

   fair_rotate_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      tenure == `FAIR_LIMIT && others && !lock_i && !busy_i |=> owner != $past(owner))
      else $error("fairness did not rotate owner");
endmodule : bus_arbiter
`default_nettype wire

// [hw/ext_port.sv]
// Functional notes
// - one 32-bit address bus and one 32-bit data bus outside.
// - pipelined, slow with acknowledge, and sdram protocols supported.
// - high address bits decoded internally into bank select outputs.
// - programmable pipe depth and idle cycles; acknowledge stretches slow accesses.
// - device-to-host pipelined or slow; host-to-device pipelined only.
// - host burst: address increments internally while burst continue held.
// - back-off abandons transaction, grants host, releases bus.
// - host reads and writes internal memory and registers directly.
// - distributed arbitration for eight peers and a host, no arbiter.
// - peers are granted by rotating priority.
// - bus lock holds ownership from locked read to following write.
// - fairness limits how long one peer keeps the bus.
// - sdram moves one 32-bit word per access: ras, cas, then data two clocks after cas.
// - up to four sdram banks selected from address, parts 16M to 512M.
// - eprom boot after reset, sixteen wait cycles per byte read.
// - boot memory select acts as eprom chip select.
// - channel zero packs four eprom bytes into one 32-bit word.
// - eprom space is 24-bit byte addressed, reached only by dma.
// - flyby releases data bus, drives address, selects and io strobes.
// - full 32-bit external word address space passed through.
// - all external signals run on the bus clock.
`timescale 1ns/10ps
`default_nettype none
`include "ext_port_defs.svh"
module ext_port
   import ext_port_pkg::*;
(
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic [1:0] pipe_depth_i,
   input wire logic [1:0] idle_cycles_i,
   input wire logic host_slow_i,
   input wire logic [2:0] bus_width_i,
   input wire logic [2:0] proc_id_i,
   input wire logic boot_eprom_i,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic req_lock_i,
   input wire logic [31:0] req_addr_i,
   input wire logic [31:0] req_wdata_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic rsp_abort_o,
   output logic [31:0] rsp_data_o,
   input wire logic eprom_req_i,
   input wire logic eprom_write_i,
   input wire logic [23:0] eprom_addr_i,
   input wire logic [7:0] eprom_wdata_i,
   output logic eprom_ready_o,
   output logic eprom_done_o,
   input wire logic flyby_req_i,
   input wire logic flyby_to_sdram_i,
   input wire logic [31:0] flyby_addr_i,
   output logic flyby_ready_o,
   output logic flyby_done_o,
   output logic mem_valid_o,
   output logic mem_write_o,
   output logic [31:0] mem_addr_o,
   output logic [31:0] mem_wdata_o,
   input wire logic [31:0] mem_rdata_i,
   output logic boot_busy_o,
   output logic width_fault_o,
   output logic [31:0] addr_o,
   output logic addr_oe_o,
   input wire logic [31:0] data_i,
   output logic [31:0] data_o,
   output logic data_oe_o,
   output logic read_strobe_o,
   output logic write_strobe_o,
   input wire logic ack_i,
   output logic [1:0] mem_bank_selects_o,
   output logic [3:0] sdram_bank_selects_o,
   output logic sdram_ras_o,
   output logic sdram_cas_o,
   output logic sdram_we_o,
   output logic boot_memory_select_o,
   output logic io_read_strobe_o,
   output logic io_write_strobe_o,
   output logic io_buffer_enable_o,
   input wire logic [7:0] bus_req_i,
   output logic bus_req_o,
   output logic lock_o,
   input wire logic host_bus_req_i,
   output logic host_bus_grant_o,
   input wire logic back_off_request_n_i,
   input wire logic host_access_i,
   input wire logic host_write_i,
   input wire logic [31:0] host_addr_i,
   input wire logic burst_continue_i
);
   mstate_t state, next_state;
   kind_t kind, next_kind;
   logic [4:0] cnt, next_cnt;
   logic [31:0] addr_q, next_addr, data_q, next_data, rsp_data, next_rsp_data;
   logic [31:0] mem_addr, next_mem_addr, mem_wdata, next_mem_wdata, pack, next_pack;
   logic [23:0] rom_addr, next_rom_addr;
   logic [15:0] word_cnt, next_word_cnt;
   logic [3:0] sd_sel, next_sd_sel;
   logic [1:0] mem_sel, next_mem_sel, byte_idx, next_byte_idx;
   logic write_q, next_write, rsp_valid, next_rsp_valid, rsp_abort, next_rsp_abort;
   logic mem_valid, next_mem_valid, mem_write, next_mem_write, lock_q, next_lock;
   logic boot_active, next_boot_active, boot_seen, next_boot_seen;
   logic burst_active, next_burst, host_rd, next_host_rd, from_core, next_from_core;
   logic eprom_done, next_eprom_done, flyby_done, next_flyby_done, width_fault, next_width_fault;
   logic own_grant, host_grant, backoff, host_acc, idle_free, in_eprom, in_fly, in_xfer, strobe_phase;

   function automatic kind_t classify(input logic [31:0] a, input logic slow);
      if (a[`REGION_HI:`REGION_LO] == `REGION_SDRAM)
         return kind_sdram;
      else if (a[`REGION_HI:`REGION_LO] == `REGION_HOST && slow)
         return kind_slow;
      else
         return kind_pipe;
   endfunction : classify

   function automatic logic [3:0] sd_select(input logic [31:0] a);
      sd_select = 4'h0;
      if (a[`REGION_HI:`REGION_LO] == `REGION_SDRAM)
         sd_select = 4'h1 << a[`BANK_HI:`BANK_LO];
   endfunction : sd_select

   assign backoff = !back_off_request_n_i;
   assign host_acc = host_access_i && host_grant;
   assign idle_free = state == st_idle && own_grant && !backoff;
   assign in_eprom = state == st_eprom;
   assign in_fly = state == st_fly;
   assign in_xfer = state == st_addr || state == st_wait;

   bus_arbiter u_arb (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .bus_req_i(bus_req_i),
      .proc_id_i(proc_id_i),
      .own_req_i(bus_req_o),
      .lock_i(lock_q),
      .busy_i(state != st_idle),
      .host_req_i(host_bus_req_i),
      .back_off_n_i(back_off_request_n_i),
      .own_grant_o(own_grant),
      .host_grant_o(host_grant)
   );

   always_comb
   begin
      next_state = state;
      next_kind = kind;
      next_cnt = cnt;
      next_addr = addr_q;
      next_data = data_q;
      next_rsp_data = rsp_data;
      next_mem_addr = mem_addr;
      next_mem_wdata = mem_wdata;
      next_pack = pack;
      next_rom_addr = rom_addr;
      next_word_cnt = word_cnt;
      next_sd_sel = sd_sel;
      next_mem_sel = mem_sel;
      next_byte_idx = byte_idx;
      next_write = write_q;
      next_mem_write = mem_write;
      next_lock = lock_q;
      next_boot_active = boot_active;
      next_boot_seen = 1'b1;
      next_from_core = from_core;
      next_rsp_valid = 1'b0;
      next_rsp_abort = 1'b0;
      next_mem_valid = 1'b0;
      next_eprom_done = 1'b0;
      next_flyby_done = 1'b0;
      next_width_fault = bus_width_i != `WIDTH_OK;
      // boot strap caught on the first clock after reset release
      if (!boot_seen)
         next_boot_active = boot_eprom_i;
      // host slave path, pipelined only
      next_host_rd = host_acc && !host_write_i;
      next_burst = host_acc ? burst_continue_i : burst_active && burst_continue_i;
      if (host_acc)
      begin
         next_mem_valid = 1'b1;
         next_mem_write = host_write_i;
         next_mem_wdata = data_i;
         if (burst_active && burst_continue_i)
            next_mem_addr = mem_addr + `ONE32;
         else
            next_mem_addr = host_addr_i;
      end
      if (host_rd)
         next_data = mem_rdata_i;
      if (backoff && state != st_idle)
      begin
         // abandoned byte is refetched later, pack only advances on completion
         next_state = st_idle;
         next_rsp_abort = from_core;
         next_from_core = 1'b0;
         next_lock = 1'b0;
      end
      else
      begin
         case (state)
            st_idle:
               if (idle_free && (boot_active || eprom_req_i))
               begin
                  next_state = st_eprom;
                  next_cnt = `EPROM_WAIT;
                  next_addr = {`ROM_PAD, boot_active ? rom_addr : eprom_addr_i};
                  next_write = !boot_active && eprom_write_i;
                  next_data = {`BYTE_PAD, eprom_wdata_i};
               end
               else if (idle_free && flyby_req_i)
               begin
                  next_state = st_fly;
                  next_addr = flyby_addr_i;
                  next_sd_sel = sd_select(flyby_addr_i);
                  next_write = flyby_to_sdram_i;
               end
               else if (idle_free && req_valid_i)
               begin
                  next_state = st_addr;
                  next_addr = req_addr_i;
                  next_data = req_wdata_i;
                  next_write = req_write_i;
                  next_kind = classify(req_addr_i, host_slow_i);
                  next_sd_sel = sd_select(req_addr_i);
                  next_mem_sel = 2'b01 << req_addr_i[`MSEL_BIT];
                  next_from_core = 1'b1;
                  if (req_lock_i && !req_write_i)
                     next_lock = 1'b1;
               end
            st_addr:
            begin
               next_state = st_wait;
               if (kind == kind_sdram)
                  next_cnt = `SDRAM_CL;
               else
                  next_cnt = {`CNT_PAD, pipe_depth_i};
            end
            st_wait:
               if (kind == kind_slow ? ack_i : cnt == '0)
               begin
                  next_rsp_valid = 1'b1;
                  next_rsp_data = write_q ? data_q : data_i;
                  if (write_q)
                     next_lock = 1'b0;
                  next_from_core = 1'b0;
                  next_cnt = {`CNT_PAD, idle_cycles_i};
                  next_state = idle_cycles_i == '0 ? st_idle : st_gap;
               end
               else if (kind != kind_slow)
                  next_cnt = cnt - 5'h01;
            st_gap:
               if (cnt == 5'h01)
                  next_state = st_idle;
               else
                  next_cnt = cnt - 5'h01;
            st_eprom:
               if (cnt == '0)
               begin
                  next_state = st_idle;
                  if (boot_active)
                  begin
                     // first byte ends up in the low lane
                     next_pack = {data_i[7:0], pack[31:8]};
                     next_byte_idx = byte_idx + 2'h1;
                     next_rom_addr = rom_addr + `ONE24;
                     if (byte_idx == 2'h3)
                     begin
                        next_mem_valid = 1'b1;
                        next_mem_write = 1'b1;
                        next_mem_addr = {`WORD_PAD, word_cnt};
                        next_mem_wdata = {data_i[7:0], pack[31:8]};
                        next_word_cnt = word_cnt + 16'h0001;
                        if (word_cnt == `BOOT_LAST)
                           next_boot_active = 1'b0;
                     end
                  end
                  else
                  begin
                     next_eprom_done = 1'b1;
                     next_rsp_data = {`BYTE_PAD, data_i[7:0]};
                  end
               end
               else
                  next_cnt = cnt - 5'h01;
            st_fly:
               if (ack_i)
               begin
                  next_flyby_done = 1'b1;
                  next_state = st_idle;
               end
            default:
               next_state = st_idle;
         endcase
      end
   end

   // single bus clock for everything facing the pins
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state <= st_idle;
         kind <= kind_pipe;
         cnt <= '0;
         addr_q <= '0;
         data_q <= '0;
         rsp_data <= '0;
         mem_addr <= '0;
         mem_wdata <= '0;
         pack <= '0;
         rom_addr <= '0;
         word_cnt <= '0;
         sd_sel <= '0;
         mem_sel <= '0;
         byte_idx <= '0;
         write_q <= '0;
         mem_write <= '0;
         lock_q <= '0;
         boot_active <= '0;
         boot_seen <= '0;
         from_core <= '0;
         rsp_valid <= '0;
         rsp_abort <= '0;
         mem_valid <= '0;
         eprom_done <= '0;
         flyby_done <= '0;
         width_fault <= '0;
         host_rd <= '0;
         burst_active <= '0;
      end
      else
      begin
         state <= next_state;
         kind <= next_kind;
         cnt <= next_cnt;
         addr_q <= next_addr;
         data_q <= next_data;
         rsp_data <= next_rsp_data;
         mem_addr <= next_mem_addr;
         mem_wdata <= next_mem_wdata;
         pack <= next_pack;
         rom_addr <= next_rom_addr;
         word_cnt <= next_word_cnt;
         sd_sel <= next_sd_sel;
         mem_sel <= next_mem_sel;
         byte_idx <= next_byte_idx;
         write_q <= next_write;
         mem_write <= next_mem_write;
         lock_q <= next_lock;
         boot_active <= next_boot_active;
         boot_seen <= next_boot_seen;
         from_core <= next_from_core;
         rsp_valid <= next_rsp_valid;
         rsp_abort <= next_rsp_abort;
         mem_valid <= next_mem_valid;
         eprom_done <= next_eprom_done;
         flyby_done <= next_flyby_done;
         width_fault <= next_width_fault;
         host_rd <= next_host_rd;
         burst_active <= next_burst;
      end
   end

   assign strobe_phase = state == st_addr || (state == st_wait && kind == kind_slow) || in_eprom || in_fly;
   assign addr_o = addr_q;
   assign addr_oe_o = in_xfer || in_eprom || in_fly;
   assign data_o = data_q;
   // flyby leaves the data lines to the io device and sdram
   assign data_oe_o = (write_q && (in_xfer || in_eprom)) || host_rd;
   assign read_strobe_o = strobe_phase && !write_q;
   assign write_strobe_o = strobe_phase && write_q;
   assign mem_bank_selects_o = in_xfer && kind != kind_sdram ? mem_sel : 2'b00;
   assign sdram_bank_selects_o = (in_xfer && kind == kind_sdram) || in_fly ? sd_sel : 4'h0;
   assign sdram_ras_o = state == st_addr && kind == kind_sdram;
   assign sdram_cas_o = state == st_wait && kind == kind_sdram && cnt == `SDRAM_CL;
   assign sdram_we_o = sdram_cas_o && write_q;
   assign boot_memory_select_o = in_eprom;
   assign io_buffer_enable_o = in_fly;
   assign io_read_strobe_o = in_fly && write_q;
   assign io_write_strobe_o = in_fly && !write_q;
   assign bus_req_o = boot_active || eprom_req_i || flyby_req_i || req_valid_i || state != st_idle || lock_q;
   assign eprom_ready_o = idle_free && !boot_active && eprom_req_i;
   assign flyby_ready_o = idle_free && !boot_active && !eprom_req_i && flyby_req_i;
   assign req_ready_o = idle_free && !boot_active && !eprom_req_i && !flyby_req_i && req_valid_i;
   assign rsp_valid_o = rsp_valid;
   assign rsp_abort_o = rsp_abort;
   assign rsp_data_o = rsp_data;
   assign eprom_done_o = eprom_done;
   assign flyby_done_o = flyby_done;
   assign mem_valid_o = mem_valid;
   assign mem_write_o = mem_write;
   assign mem_addr_o = mem_addr;
   assign mem_wdata_o = mem_wdata;
   assign boot_busy_o = boot_active;
   assign width_fault_o = width_fault;
   assign lock_o = lock_q;
   assign host_bus_grant_o = host_grant;

   backoff_release_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      backoff |=> host_bus_grant_o && !addr_oe_o && state == st_idle)
      else $error("back-off did not release bus");

   eprom_wait_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      $fell(in_eprom) && $past(back_off_request_n_i) |-> $past(in_eprom, 17) && !$past(in_eprom, 18))
      else $error("eprom read not 16 wait cycles");

   boot_select_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      boot_memory_select_o |-> addr_oe_o && addr_o[31:24] == `ROM_PAD && sdram_bank_selects_o == 4'h0)
      else $error("boot select outside eprom cycle");

   burst_step_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      host_acc && burst_active && burst_continue_i |=> mem_valid_o && mem_addr_o == $past(mem_addr_o) + `ONE32)
      else $error("burst address not incremented");

   burst_fresh_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      host_acc && !burst_active |=> mem_addr_o == $past(host_addr_i))
      else $error("fresh host access lost its address");

   slow_ack_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      state == st_wait && kind == kind_slow && !ack_i && !backoff |=> state == st_wait && read_strobe_o != write_strobe_o)
      else $error("slow access ended without acknowledge");

   sdram_latency_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      rsp_valid_o && $past(kind == kind_sdram) |-> $past(sdram_cas_o, 3) && $past(sdram_ras_o, 4))
      else $error("sdram data not at cas latency");

   flyby_release_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      in_fly && !backoff && ack_i |-> !data_oe_o && io_buffer_enable_o ##1 flyby_done_o && !in_fly)
      else $error("flyby drove data or missed done");
endmodule : ext_port
`default_nettype wire

// [tb/far_side_model.sv]
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
   input wire logic clock_i,
   input wire logic [31:0] addr_i,
   input wire logic addr_oe_i,
   input wire logic read_strobe_i,
   input wire logic write_strobe_i,
   output logic [31:0] data_o,
   output logic ack_o
);
   logic [31:0] noise = 32'h0;
   logic [1:0] held = 2'h0;
   always_ff @(posedge clock_i)
   begin
      noise <= ~noise ^ {noise[30:0], 1'b1};
      held <= (read_strobe_i | write_strobe_i) ? held + 2'h1 : 2'h0;
   end
   // released bus shows a changing pattern, never the last word
   assign data_o = ((addr_oe_i | read_strobe_i) && !write_strobe_i) ? addr_i ^ 32'hc3c3_0f0f : noise;
   assign ack_o = held == 2'h3;
endmodule : far_side_model
`default_nettype wire

// [tb/tb_external_bus_port.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_external_bus_port;
   logic clock_i, arst_n_i, host_slow_i, boot_eprom_i, req_valid_i, req_write_i, req_lock_i, req_ready_o;
   logic rsp_valid_o, rsp_abort_o, eprom_req_i, eprom_write_i, eprom_ready_o, eprom_done_o, flyby_req_i;
   logic flyby_to_sdram_i, flyby_ready_o, flyby_done_o, mem_valid_o, mem_write_o, boot_busy_o, width_fault_o;
   logic addr_oe_o, data_oe_o, read_strobe_o, write_strobe_o, ack_i, sdram_ras_o, sdram_cas_o, sdram_we_o;
   logic boot_memory_select_o, io_read_strobe_o, io_write_strobe_o, io_buffer_enable_o, bus_req_o, lock_o;
   logic host_bus_req_i, host_bus_grant_o, back_off_request_n_i, host_access_i, host_write_i, burst_continue_i;
   logic [1:0] pipe_depth_i, idle_cycles_i, mem_bank_selects_o;
   logic [2:0] bus_width_i, proc_id_i;
   logic [3:0] sdram_bank_selects_o;
   logic [7:0] eprom_wdata_i, bus_req_i;
   logic [23:0] eprom_addr_i;
   logic [31:0] req_addr_i, req_wdata_i, rsp_data_o, flyby_addr_i, mem_addr_o, mem_wdata_o, mem_rdata_i;
   logic [31:0] addr_o, data_i, data_o, host_addr_i;
   int num_errors = 0;
   int checks = 0;
   ext_port uut (.*);
   far_side_model partner (.clock_i, .addr_i(addr_o), .addr_oe_i(addr_oe_o), .read_strobe_i(read_strobe_o),
      .write_strobe_i(write_strobe_o), .data_o(data_i), .ack_o(ack_i));
   assign bus_req_i = {7'h00, bus_req_o};
   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
         num_errors++;
      end
   endtask : check
   task conclude;
      if (num_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   task issue(input logic [31:0] addr);
      int n;
      n = 0;
      req_addr_i <= addr;
      req_valid_i <= 1'b1;
      do @(negedge clock_i); while (req_ready_o !== 1'b1 && ++n < 200);
      @(posedge clock_i);
      req_valid_i <= 1'b0;
   endtask : issue
   task core_read(input logic [31:0] addr, input int lat, input logic [1:0] mbs, input logic [3:0] sbs);
      int n;
      logic [1:0] ms;
      logic [3:0] ss;
      n = 0;
      ms = 2'h0;
      ss = 4'h0;
      issue(addr);
      do
      begin
         @(negedge clock_i);
         n++;
         ms |= mem_bank_selects_o;
         ss |= sdram_bank_selects_o;
      end
      while (rsp_valid_o !== 1'b1 && n < 200);
      check(n, lat, "latency");
      check(ms, mbs, "bank select");
      check(ss, sbs, "sdram select");
      check(rsp_data_o, addr ^ 32'hc3c3_0f0f, "read data");
      @(posedge clock_i);
   endtask : core_read
   task eprom_read;
      int n;
      int s;
      n = 0;
      s = 0;
      eprom_addr_i <= 24'h12_3456;
      eprom_req_i <= 1'b1;
      do @(negedge clock_i); while (eprom_ready_o !== 1'b1 && ++n < 200);
      @(posedge clock_i);
      eprom_req_i <= 1'b0;
      n = 0;
      do
      begin
         @(negedge clock_i);
         n++;
         if (boot_memory_select_o === 1'b1)
         begin
            s++;
            check(addr_o, 32'h0012_3456, "eprom address");
         end
      end
      while (eprom_done_o !== 1'b1 && n < 200);
      check(n, 18, "eprom length");
      check(s, 17, "eprom select");
      check({24'h0, rsp_data_o[7:0]}, 32'h59, "eprom byte");
      @(posedge clock_i);
   endtask : eprom_read
   task flyby;
      int n;
      int s;
      n = 0;
      s = 0;
      flyby_addr_i <= 32'h5000_0080;
      flyby_to_sdram_i <= 1'b1;
      flyby_req_i <= 1'b1;
      do @(negedge clock_i); while (flyby_ready_o !== 1'b1 && ++n < 200);
      @(posedge clock_i);
      flyby_req_i <= 1'b0;
      n = 0;
      do
      begin
         @(negedge clock_i);
         n++;
         if (io_buffer_enable_o === 1'b1 && io_read_strobe_o === 1'b1 && write_strobe_o === 1'b1
            && data_oe_o === 1'b0 && sdram_bank_selects_o === 4'h2)
            s++;
      end
      while (flyby_done_o !== 1'b1 && n < 200);
      check(n, 5, "flyby length");
      check(s, 4, "flyby lines");
      @(posedge clock_i);
   endtask : flyby
   task back_off;
      int n;
      n = 0;
      pipe_depth_i <= 2'h3;
      issue(32'h0000_0100);
      back_off_request_n_i <= 1'b0;
      host_bus_req_i <= 1'b1;
      do @(negedge clock_i); while (rsp_abort_o !== 1'b1 && ++n < 20);
      check(rsp_abort_o, 1'b1, "abort");
      check(host_bus_grant_o, 1'b1, "host grant");
      check(addr_oe_o, 1'b0, "bus released");
      @(posedge clock_i);
      back_off_request_n_i <= 1'b1;
   endtask : back_off
   task host_burst;
      logic [31:0] want [$];
      want = '{32'h0000_0200, 32'h0000_0201, 32'h0000_0300};
      host_write_i <= 1'b1;
      for (int n = 0; n < 10; n++)
      begin
         host_access_i <= n < 3;
         host_addr_i <= n == 0 ? 32'h0000_0200 : (n == 1 ? 32'h0000_0777 : 32'h0000_0300);
         burst_continue_i <= n < 2;
         @(negedge clock_i);
         if (mem_valid_o === 1'b1 && want.size() > 0)
         begin
            check(mem_addr_o, want.pop_front(), "host address");
            check(mem_write_o, 1'b1, "host write");
         end
         @(posedge clock_i);
      end
      check(want.size(), 0, "host accesses");
   endtask : host_burst
   initial
   begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   initial
   begin
      #100000;
      num_errors++;
      conclude();
   end
   initial
   begin
      {host_slow_i, boot_eprom_i, req_valid_i, req_write_i, req_lock_i, eprom_req_i, eprom_write_i} = '0;
      {flyby_req_i, flyby_to_sdram_i, host_bus_req_i, host_access_i, host_write_i, burst_continue_i} = '0;
      {req_addr_i, req_wdata_i, flyby_addr_i, mem_rdata_i, host_addr_i, eprom_addr_i, eprom_wdata_i} = '0;
      {pipe_depth_i, idle_cycles_i, bus_width_i, proc_id_i} = '0;
      back_off_request_n_i = 1'b1;
      arst_n_i = 1'b0;
      repeat (2) @(posedge clock_i);
      arst_n_i <= 1'b1;
      bus_width_i <= 3'h4;
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      check(width_fault_o, 1'b1, "width fault");
      @(posedge clock_i);
      bus_width_i <= 3'h0;
      core_read(32'h2000_0040, 3, 2'h2, 4'h0);
      pipe_depth_i <= 2'h2;
      idle_cycles_i <= 2'h2;
      core_read(32'h0000_0044, 5, 2'h1, 4'h0);
      core_read(32'h6000_0010, 5, 2'h0, 4'h4);
      host_slow_i <= 1'b1;
      core_read(32'hc000_0020, 5, 2'h1, 4'h0);
      eprom_read();
      flyby();
      back_off();
      host_burst();
      check(width_fault_o, 1'b0, "width fault clear");
      check(boot_busy_o, 1'b0, "boot idle");
      conclude();
   end
endmodule : tb_external_bus_port
`default_nettype wire
